// ### shared/erase_ctl_map.svh
`ifndef ERASE_CTL_MAP_SVH
`define ERASE_CTL_MAP_SVH

// instruction codes seen on the serial input
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_STATUS_READ    8'h05
`define OP_SECTOR_ERASE   8'h52
`define OP_CHIP_ERASE     8'h62

// frame lengths in bits
`define OPCODE_BITS       6'h08
`define SECTOR_FRAME_BITS 6'h20

// sector geometry
`define SECTOR_COUNT      4
`define SECTOR_IDX_LSB    15
`define SECTOR_IDX_W      2

// status byte layout
`define ST_BUSY           0
`define ST_WEL            1
`define ST_PROT_LSB       2

// value every erased byte reads back as
`define ERASED_BYTE       8'hFF

// timing
`define CLK_MHZ           50
`define CHIP_ERASE_MS     3500
`define SECTOR_ERASE_MS   1000

`endif

// ### shared/erase_ctl_pkg.sv
package erase_ctl_pkg;

  typedef enum logic {PH_IDLE, PH_ERASE} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic        busy;
    logic        wel;
    logic        cs_q;
    logic        sck_q;
    logic [5:0]  nbits;
    logic [31:0] shreg;
    logic        rd;
    logic [7:0]  stat_sh;
    logic        so;
    logic        so_oe;
    logic [3:0]  mask;
    logic        chip;
    logic        done;
    logic [7:0]  pattern;
    logic [31:0] timer;
  } ctl_t;

endpackage

// ### hdl/serial_flash_erase_control.sv
// Summary of operation
// - a sector erase clears the whole addressed sector unless that sector is locked out.
// - the sector is taken from any address that lies inside it.
// - during a sector erase only the status read has any effect.
// - the write enable latch clears by itself when a sector erase ends.
// - a chip erase clears every sector that is not locked out and leaves the rest.
// - the chip erase busy time is a count derived from 3.5 seconds.
// - during a chip erase only the status read has any effect.
// - the write enable latch clears by itself when a chip erase ends.
// - status bit 0 reads one while an erase runs and zero after it.
// - only sectors outside the protected range may ever be changed.
// - a modifying instruction without the latch set is dropped at chip select rise.
`timescale 1ns/1ps
`include "erase_ctl_map.svh"

module serial_flash_erase_control
  import erase_ctl_pkg::*;
#(
  parameter int unsigned CHIP_ERASE_CYC   = `CHIP_ERASE_MS * 1000 * `CLK_MHZ,
  parameter int unsigned SECTOR_ERASE_CYC = `SECTOR_ERASE_MS * 1000 * `CLK_MHZ
)
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     ce,
  input  wire logic                     cs_b,
  input  wire logic                     sck,
  input  wire logic                     si,
  input  wire logic                     protect_level_bit_low,
  input  wire logic                     protect_level_bit_high,
  output logic                          so,
  output logic                          so_oe,
  output logic                          busy,
  output logic                          wel,
  output logic [`SECTOR_COUNT-1:0]      erase_mask,
  output logic                          erase_chip,
  output logic                          erase_done,
  output logic [7:0]                    erase_pattern
);

  ctl_t       st_r;
  ctl_t       st_nxt;
  logic [1:0] prot;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;

  assign prot = {protect_level_bit_high, protect_level_bit_low};

  // level 1 locks the top quarter, level 2 the top half, level 3 all
  function automatic logic [`SECTOR_COUNT-1:0] lock_mask(input logic [1:0] lvl);
    logic [`SECTOR_COUNT-1:0] m;
    m = '0;
    for (int i = 0; i < `SECTOR_COUNT; i++)
    begin
      unique case (lvl)
        2'h0: m[i] = 1'b0;
        2'h1: m[i] = (i >= `SECTOR_COUNT - `SECTOR_COUNT / 4);
        2'h2: m[i] = (i >= `SECTOR_COUNT / 2);
        2'h3: m[i] = 1'b1;
      endcase
    end
    return m;
  endfunction

  assign sck_rise = sck & ~st_r.sck_q;
  assign sck_fall = ~sck & st_r.sck_q;
  assign cs_rise  = cs_b & ~st_r.cs_q;

  always_comb
  begin
    logic [`SECTOR_COUNT-1:0] sel;
    logic [`SECTOR_IDX_W-1:0] idx;
    logic [`SECTOR_COUNT-1:0] open_m;
    sel    = '0;
    idx    = st_r.shreg[`SECTOR_IDX_LSB +: `SECTOR_IDX_W];
    open_m = ~lock_mask(prot);
    sel[idx] = 1'b1;
    st_nxt         = st_r;
    st_nxt.cs_q    = cs_b;
    st_nxt.sck_q   = sck;
    st_nxt.done    = 1'b0;
    st_nxt.pattern = `ERASED_BYTE;

    // serial shifter, msb first, sampled on the rising clock edge
    if (!cs_b && sck_rise)
    begin
      st_nxt.shreg = {st_r.shreg[30:0], si};
      if (st_r.nbits != 6'h3F)
        st_nxt.nbits = st_r.nbits + 6'h01;
      // status read is the one instruction honoured even while busy
      if (st_r.nbits == `OPCODE_BITS - 6'h01 && {st_r.shreg[6:0], si} == `OP_STATUS_READ)
      begin
        st_nxt.rd      = 1'b1;
        st_nxt.stat_sh = {4'h0, prot, st_r.wel, st_r.busy};
        st_nxt.so_oe   = 1'b1;
      end
    end
    // status shifts out on the falling edge, valid for modes 0 and 3
    if (!cs_b && sck_fall && st_r.rd)
    begin
      st_nxt.so      = st_r.stat_sh[7];
      st_nxt.stat_sh = {st_r.stat_sh[6:0], st_r.busy};
    end
    if (cs_b)
    begin
      st_nxt.nbits = '0;
      st_nxt.rd    = 1'b0;
      st_nxt.so_oe = 1'b0;
    end

    // instructions act when chip select rises, and only when idle
    if (cs_rise && st_r.phase == PH_IDLE)
    begin
      if (st_r.nbits == `OPCODE_BITS && st_r.shreg[7:0] == `OP_WRITE_ENABLE)
        st_nxt.wel = 1'b1;
      else if (st_r.nbits == `OPCODE_BITS && st_r.shreg[7:0] == `OP_WRITE_DISABLE)
        st_nxt.wel = 1'b0;
      else if (st_r.wel && st_r.nbits == `SECTOR_FRAME_BITS
               && st_r.shreg[31:24] == `OP_SECTOR_ERASE && |(sel & open_m))
      begin
        st_nxt.phase = PH_ERASE;
        st_nxt.busy  = 1'b1;
        st_nxt.mask  = sel & open_m;
        st_nxt.chip  = 1'b0;
        st_nxt.timer = SECTOR_ERASE_CYC - 1;
      end
      else if (st_r.wel && st_r.nbits == `OPCODE_BITS
               && st_r.shreg[7:0] == `OP_CHIP_ERASE && |open_m)
      begin
        st_nxt.phase = PH_ERASE;
        st_nxt.busy  = 1'b1;
        st_nxt.mask  = open_m;
        st_nxt.chip  = 1'b1;
        st_nxt.timer = CHIP_ERASE_CYC - 1;
      end
    end

    unique case (st_r.phase)
      PH_IDLE:
        ;
      PH_ERASE:
      begin
        if (st_r.timer == '0)
        begin
          st_nxt.phase = PH_IDLE;
          st_nxt.busy  = 1'b0;
          st_nxt.wel   = 1'b0;
          st_nxt.mask  = '0;
          st_nxt.done  = 1'b1;
        end
        else
          st_nxt.timer = st_r.timer - 32'h0000_0001;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      st_r         <= '0;
      st_r.phase   <= PH_IDLE;
      st_r.cs_q    <= 1'b1;
      st_r.pattern <= `ERASED_BYTE;
    end
    else if (ce)
      st_r <= st_nxt;
  end

  assign so            = st_r.so;
  assign so_oe         = st_r.so_oe;
  assign busy          = st_r.busy;
  assign wel           = st_r.wel;
  assign erase_mask    = st_r.mask;
  assign erase_chip    = st_r.chip;
  assign erase_done    = st_r.done;
  assign erase_pattern = st_r.pattern;

  // checks
  property p_wel_off_at_end;
    @(posedge clk_sys) disable iff (!rst_b) $rose(st_r.done) |-> !st_r.wel && !st_r.busy;
  endproperty
  a_wel_off_at_end: assert property (p_wel_off_at_end) else $error("wel kept after erase");

  property p_chip_wel_off;
    @(posedge clk_sys) disable iff (!rst_b)
      st_r.busy && st_r.chip ##1 !st_r.busy |-> !st_r.wel;
  endproperty
  a_chip_wel_off: assert property (p_chip_wel_off) else $error("wel kept after chip erase");

  property p_mask_frozen;
    @(posedge clk_sys) disable iff (!rst_b)
      $past(st_r.busy) && st_r.busy |-> $stable(st_r.mask) && $stable(st_r.chip);
  endproperty
  a_mask_frozen: assert property (p_mask_frozen) else $error("target changed while busy");

  property p_wel_frozen;
    @(posedge clk_sys) disable iff (!rst_b) $past(st_r.busy) && st_r.busy |-> $stable(st_r.wel);
  endproperty
  a_wel_frozen: assert property (p_wel_frozen) else $error("instruction acted while busy");

  property p_no_locked;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(st_r.busy) |-> (st_r.mask & lock_mask($past(prot))) == '0 && st_r.mask != '0;
  endproperty
  a_no_locked: assert property (p_no_locked) else $error("locked sector selected");

  property p_needs_wel;
    @(posedge clk_sys) disable iff (!rst_b) $rose(st_r.busy) |-> $past(st_r.wel) && $past(cs_b);
  endproperty
  a_needs_wel: assert property (p_needs_wel) else $error("erase without write enable");

  property p_chip_time;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(st_r.busy) && st_r.chip |-> st_r.timer == CHIP_ERASE_CYC - 1
        && st_r.mask == ~lock_mask($past(prot));
  endproperty
  a_chip_time: assert property (p_chip_time) else $error("chip erase load wrong");

  property p_one_sector;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(st_r.busy) && !st_r.chip |-> $onehot(st_r.mask)
        && st_r.timer == SECTOR_ERASE_CYC - 1;
  endproperty
  a_one_sector: assert property (p_one_sector) else $error("sector erase load wrong");

  property p_pattern;
    @(posedge clk_sys) disable iff (!rst_b) ##1 st_r.pattern == `ERASED_BYTE;
  endproperty
  a_pattern: assert property (p_pattern) else $error("erase pattern not all ones");

  property p_status_busy;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(st_r.rd) |-> st_r.stat_sh[`ST_BUSY] == $past(st_r.busy);
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("status busy bit wrong");

  c_sector: cover property (@(posedge clk_sys) $rose(st_r.busy) && !st_r.chip);
  c_chip:   cover property (@(posedge clk_sys) $rose(st_r.busy) && st_r.chip);
  c_poll:   cover property (@(posedge clk_sys) st_r.busy && $rose(st_r.rd));
  c_done:   cover property (@(posedge clk_sys) st_r.done);

endmodule

// ### testbench/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model
  import erase_ctl_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic so,
  output logic      cs_b,
  output logic      sck,
  output logic      si
);
  initial
  begin
    cs_b = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // idle level cpol picks mode 0 or 3; msb first from bit 31; status sampled late in sck low
  task automatic xfer(input logic [31:0] data, input int n, input logic cpol,
                      output logic [7:0] rd);
    rd  = 8'h00;
    sck = cpol;
    tick(1);
    cs_b = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sck = 1'b0;
      si  = data[31-i];
      tick(2);
      if (i >= 8)
        rd = {rd[6:0], so};
      sck = 1'b1;
      tick(2);
    end
    sck = cpol;
    si  = ~si;
    tick(2);
    // cs rises at the idle sck level; gap between frames kept above two clocks
    cs_b = 1'b1;
    tick(3);
  endtask
endmodule

// ### testbench/serial_flash_erase_control_tb_top.sv
`timescale 1ns/1ps
`include "erase_ctl_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end

module serial_flash_erase_control_tb_top
  import erase_ctl_pkg::*;
;
  localparam int unsigned CHIP_CYC = 400;
  localparam int unsigned SECT_CYC = 200;

  logic                     clk_sys, rst_b, ce, cs_b, sck, si, prot_lo, prot_hi;
  logic                     so, so_oe, busy, wel, erase_chip, erase_done;
  logic [`SECTOR_COUNT-1:0] erase_mask;
  logic [7:0]               erase_pattern, rd;
  logic                     so_line, cpol;
  int                       mismatches, checked, busy_len, busy_base;

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (busy === 1'b1)
      busy_len++;

  serial_flash_erase_control #(.CHIP_ERASE_CYC(CHIP_CYC), .SECTOR_ERASE_CYC(SECT_CYC)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .cs_b(cs_b), .sck(sck), .si(si),
    .protect_level_bit_low(prot_lo), .protect_level_bit_high(prot_hi), .so(so),
    .so_oe(so_oe), .busy(busy), .wel(wel), .erase_mask(erase_mask),
    .erase_chip(erase_chip), .erase_done(erase_done), .erase_pattern(erase_pattern));

  // a released line shows the inverse, so a late or missing enable spoils the status byte
  assign so_line = so_oe ? so : ~so;

  spi_host_model i_host (.clk_sys(clk_sys), .so(so_line), .cs_b(cs_b), .sck(sck), .si(si));

  task automatic end_of_test();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic op(input logic [7:0] code, input logic [23:0] addr, input int n);
    i_host.xfer({code, addr}, n, cpol, rd);
  endtask

  task automatic status(input logic [7:0] exp);
    i_host.xfer({`OP_STATUS_READ, 24'h0}, 16, cpol, rd);
    `CHK(rd, exp)
  endtask

  task automatic wait_done(input int bound);
    int k;
    k = 0;
    while (erase_done !== 1'b1 && k < bound)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (erase_done !== 1'b1)
    begin
      mismatches++;
      end_of_test();
    end
    else
    begin
      // the end pulse lasts one clock only
      @(posedge clk_sys);
      #1;
      `CHK(erase_done, 1'b0)
    end
  endtask

  initial
  begin
    {rst_b, prot_lo, prot_hi, cpol, rd} = '0;
    ce = 1'b1;
    {mismatches, checked} = '0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    `CHK(erase_pattern, `ERASED_BYTE)
    `CHK({busy, wel, erase_mask}, 6'h00)
    op(`OP_SECTOR_ERASE, 24'h00_9ABC, 32);
    `CHK({busy, wel}, 2'b00)
    op(`OP_WRITE_ENABLE, 24'h0, 8);
    `CHK(wel, 1'b1)
    busy_base = busy_len;
    op(`OP_SECTOR_ERASE, 24'hFE_9ABC, 32);
    `CHK({busy, erase_chip, erase_mask}, 6'b10_0010)
    op(`OP_WRITE_DISABLE, 24'h0, 8);
    status(8'h03);
    // clock enable low holds the erase timer, so busy stretches by the frozen clocks
    ce = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK({busy, wel, erase_mask}, 6'b11_0010)
    ce = 1'b1;
    wait_done(SECT_CYC);
    `CHK({busy, wel, erase_mask}, 6'h00)
    `CHK(busy_len - busy_base, SECT_CYC + 10)
    status(8'h00);
    prot_lo = 1'b1;
    op(`OP_WRITE_ENABLE, 24'h0, 8);
    op(`OP_SECTOR_ERASE, 24'h01_8001, 32);
    `CHK({busy, wel}, 2'b01)
    busy_base = busy_len;
    op(`OP_CHIP_ERASE, 24'h0, 8);
    `CHK({busy, erase_chip, erase_mask}, 6'b11_0111)
    op(`OP_SECTOR_ERASE, 24'h00_0000, 32);
    `CHK(erase_mask, 4'b0111)
    status(8'h07);
    wait_done(CHIP_CYC);
    `CHK(busy_len - busy_base, CHIP_CYC)
    `CHK({busy, wel}, 2'b00)
    // the rest runs in mode 3: sck idles high between frames
    cpol = 1'b1;
    prot_hi = 1'b1;
    op(`OP_WRITE_ENABLE, 24'h0, 8);
    op(`OP_CHIP_ERASE, 24'h0, 8);
    `CHK({busy, wel}, 2'b01)
    status(8'h0E);
    {prot_lo, prot_hi} = 2'b00;
    op(`OP_WRITE_DISABLE, 24'h0, 8);
    op(`OP_CHIP_ERASE, 24'h0, 8);
    `CHK({busy, wel}, 2'b00)
    `CHK(so_oe, 1'b0)
    end_of_test();
  end
endmodule
